/* pkg/irwl_consts.vh */
// Operation
// R1: While learning, every falling edge of the receive input raises a capture event.
// R2: Starting a learn clears capture state, drives transmit and driver-control low, clears the edge flag and enables edge events;
// here a learn started during replay leaves tx_run set, so the transmit output keeps pulsing while driver-control goes low.
// R3: Each edge event first clears its flag and is recorded only in the await-key or capture-begun state.
// R4: Segment durations are stored in order, carrier, gap, carrier, gap, in a segment buffer.
// R5: The carrier period is the average of several single carrier pulse periods.
// R6: If the timeout limit passes after start with no edge, learning ends in a timeout failure.
// R7: After edges have arrived, learning completes when the end threshold passes with no edge.
// R8: Completion is a success only when the segment count exceeds a minimum, 15 by default, else failure.
// R9: Replay sends the learned carrier at one-third duty, each segment in carrier then gap order.
// R10: Entering transmit hands the transmit pin to the pulse generator and stops learning until a new start.
// R11: A busy flag stands while sending, and suspend is blocked while it is set.
// R12: Repeat and idle-repeat frames are replayed back to back from the buffer without gaps.
// R13: An inter-edge interval above the gap threshold closes the carrier segment and starts a new one.
// R14: Status reads 0 on success, 1 in progress or idle, and a larger failure code otherwise.
// R15: Timestamps come from a free-running counter wide enough to span the timeout.
`ifndef IRWL_CONSTS_VH
`define IRWL_CONSTS_VH
`define IRWL_CLK_MHZ          200
`define IRWL_TIMEOUT_MS       10000
`define IRWL_END_MS           30
`define IRWL_MAX_CYCLE_NS     33334
`define IRWL_MIN_SEGS         8'h0F
`define IRWL_PERIOD_SAMPLES   8
`define IRWL_PERIOD_SHIFT     3
`define IRWL_ST_IDLE          8'h01
`define IRWL_ST_SUCCESS       8'h00
`define IRWL_ST_FAIL_TIMEOUT  8'h08
`define IRWL_ST_FAIL_FEW      8'h09
`define IRWL_ST_FAIL_FULL     8'h0A
`define IRWL_A_CTRL           4'h0
`define IRWL_A_STATUS         4'h1
`define IRWL_A_PERIOD         4'h2
`define IRWL_A_COUNT          4'h3
`define IRWL_A_INT_STAT       4'h4
`define IRWL_A_INT_MASK       4'h5
`define IRWL_A_BUF            4'h6
`define IRWL_A_MIN            4'h7
`define IRWL_A_REPEAT         4'h8
`define IRWL_CTRL_LEARN       0
`define IRWL_CTRL_SEND        1
`define IRWL_INT_DONE         0
`define IRWL_INT_SENT         1
`define IRWL_RESP_OK          2'b00
`define IRWL_RESP_ERR         2'b10
`endif

/* rtl/irwl_top.v */
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`include "irwl_consts.vh"
`default_nettype none
module irwl_top #(
  parameter integer SEG_DEPTH     = 64,
  parameter integer TS_W          = 32,
  parameter integer TIMEOUT_TICKS = `IRWL_TIMEOUT_MS * 1000 * `IRWL_CLK_MHZ,
  parameter integer END_TICKS     = `IRWL_END_MS * 1000 * `IRWL_CLK_MHZ
) (
  input  wire        I_CLK,
  input  wire        I_RST_N,
  input  wire        I_IR_RECEIVE_INPUT_N,
  output reg         O_IR_TRANSMIT_OUTPUT,
  output reg         O_IR_DRIVER_CONTROL,
  output reg         O_TRANSMIT_BUSY,
  output reg         O_SUSPEND_BLOCK,
  output reg         O_IRQ,
  input  wire [31:0] I_AWADDR,
  input  wire        I_AWVALID,
  output reg         O_AWREADY,
  input  wire [31:0] I_WDATA,
  input  wire [3:0]  I_WSTRB,
  input  wire        I_WVALID,
  output reg         O_WREADY,
  output reg  [1:0]  O_BRESP,
  output reg         O_BVALID,
  input  wire        I_BREADY,
  input  wire [31:0] I_ARADDR,
  input  wire        I_ARVALID,
  output reg         O_ARREADY,
  output reg  [31:0] O_RDATA,
  output reg  [1:0]  O_RRESP,
  output reg         O_RVALID,
  input  wire        I_RREADY
);
  localparam integer GAP_TICKS =
    (`IRWL_MAX_CYCLE_NS * `IRWL_CLK_MHZ / 1000) * 3 / 2;
  localparam integer AW = (SEG_DEPTH > 1) ? $clog2(SEG_DEPTH) : 1;
  localparam [4:0] L_IDLE = 5'b00001;
  localparam [4:0] L_WAIT = 5'b00010;
  localparam [4:0] L_BEGIN = 5'b00100;
  localparam [4:0] L_DONE = 5'b01000;
  localparam [4:0] L_SEND = 5'b10000;

  ////////////////////////////////////////////////////////////////////////////
  reg  [TS_W-1:0] ts_now;
  reg  [TS_W-1:0] ts_start;
  reg  [TS_W-1:0] ts_last;
  reg  [TS_W-1:0] ts_seg;
  reg  [TS_W-1:0] seg_mem [0:SEG_DEPTH-1];
  reg  [AW:0]     seg_cnt;
  reg  [4:0]      lstate;
  reg  [7:0]      status;
  reg  [7:0]      min_segs;
  reg  [7:0]      repeat_n;
  reg  [3:0]      per_n;
  reg  [TS_W+3:0] per_sum;
  reg  [TS_W-1:0] period;
  reg             rx_prev;
  reg             edge_flag;
  reg             edge_en;
  reg  [1:0]      int_stat;
  reg  [1:0]      int_mask;
  wire [TS_W-1:0] since_last = ts_now - ts_last;
  wire [TS_W-1:0] since_start = ts_now - ts_start;
  wire [TS_W+3:0] per_total = per_sum + since_last;

  always @(posedge I_CLK)
  begin
    if (!I_RST_N)
      ts_now <= {TS_W{1'b0}};
    else
      ts_now <= ts_now + 1'b1; // R15
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: write address and data may come in either order.
  reg         aw_held;
  reg         w_held;
  reg  [3:0]  aw_idx;
  reg  [31:0] w_dat;
  reg  [3:0]  w_stb;
  reg  [AW-1:0] rd_ptr;
  wire        do_wr = aw_held && w_held && !O_BVALID;
  wire [3:0]  ar_idx = I_ARADDR[5:2];
  wire        start_learn = do_wr && aw_idx == `IRWL_A_CTRL && w_stb[0] &&
                            w_dat[`IRWL_CTRL_LEARN];
  wire        start_send = do_wr && aw_idx == `IRWL_A_CTRL && w_stb[0] &&
                           w_dat[`IRWL_CTRL_SEND] && status == `IRWL_ST_SUCCESS;

  always @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 4'h0;
      w_dat <= 32'h0;
      w_stb <= 4'h0;
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= `IRWL_RESP_OK;
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RRESP <= `IRWL_RESP_OK;
      O_RDATA <= 32'h0;
      int_mask <= 2'b00;
      min_segs <= `IRWL_MIN_SEGS;
      repeat_n <= 8'h00;
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_held <= 1'b1;
        aw_idx <= I_AWADDR[5:2];
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_held <= 1'b1;
        w_dat <= I_WDATA;
        w_stb <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (do_wr)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= (aw_idx > `IRWL_A_REPEAT) ? `IRWL_RESP_ERR : `IRWL_RESP_OK;
        if (aw_idx == `IRWL_A_INT_MASK && w_stb[0])
          int_mask <= w_dat[1:0];
        if (aw_idx == `IRWL_A_MIN && w_stb[0])
          min_segs <= w_dat[7:0];
        if (aw_idx == `IRWL_A_REPEAT && w_stb[0])
          repeat_n <= w_dat[7:0];
      end
      if (O_BVALID && I_BREADY)
      begin
        O_BVALID <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
      if (I_ARVALID && O_ARREADY)
      begin
        O_ARREADY <= 1'b0;
        O_RVALID <= 1'b1;
        O_RRESP <= `IRWL_RESP_OK;
        case (ar_idx)
          `IRWL_A_CTRL:     O_RDATA <= {27'h0, lstate};
          `IRWL_A_STATUS:   O_RDATA <= {24'h0, status}; // R14
          `IRWL_A_PERIOD:   O_RDATA <= period;
          `IRWL_A_COUNT:    O_RDATA <= {{(31-AW){1'b0}}, seg_cnt};
          `IRWL_A_INT_STAT: O_RDATA <= {30'h0, int_stat};
          `IRWL_A_INT_MASK: O_RDATA <= {30'h0, int_mask};
          `IRWL_A_BUF:      O_RDATA <= seg_mem[rd_ptr];
          `IRWL_A_MIN:      O_RDATA <= {24'h0, min_segs};
          `IRWL_A_REPEAT:   O_RDATA <= {24'h0, repeat_n};
          default:
          begin
            O_RDATA <= 32'h0;
            O_RRESP <= `IRWL_RESP_ERR;
          end
        endcase
      end
      if (O_RVALID && I_RREADY)
      begin
        O_RVALID <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Learner. An edge is latched in edge_flag, then consumed one cycle later.
  wire fall = rx_prev && !I_IR_RECEIVE_INPUT_N;
  wire done_evt = (lstate == L_WAIT || lstate == L_BEGIN) &&
                  ((lstate == L_WAIT && since_start >= TIMEOUT_TICKS) ||
                   (lstate == L_BEGIN && !edge_flag &&
                    since_last >= END_TICKS));
  reg  send_done;

  always @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      rx_prev <= 1'b1;
      edge_flag <= 1'b0;
      edge_en <= 1'b0;
      lstate <= L_IDLE;
      status <= `IRWL_ST_IDLE;
      seg_cnt <= {(AW+1){1'b0}};
      ts_start <= {TS_W{1'b0}};
      ts_last <= {TS_W{1'b0}};
      ts_seg <= {TS_W{1'b0}};
      per_n <= 4'h0;
      per_sum <= {(TS_W+4){1'b0}};
      period <= {TS_W{1'b0}};
      rd_ptr <= {AW{1'b0}};
      int_stat <= 2'b00;
    end
    else
    begin
      rx_prev <= I_IR_RECEIVE_INPUT_N;
      if (do_wr && aw_idx == `IRWL_A_INT_STAT && w_stb[0])
        int_stat <= int_stat & ~w_dat[1:0];
      if (do_wr && aw_idx == `IRWL_A_BUF)
        rd_ptr <= w_dat[AW-1:0];
      if (edge_flag)
        edge_flag <= 1'b0; // R3
      if (fall && edge_en)
        edge_flag <= 1'b1; // R1
      if (start_learn)
      begin
        lstate <= L_WAIT; // R2
        status <= `IRWL_ST_IDLE;
        seg_cnt <= {(AW+1){1'b0}};
        per_n <= 4'h0;
        per_sum <= {(TS_W+4){1'b0}};
        edge_flag <= 1'b0;
        edge_en <= 1'b1;
        ts_start <= ts_now;
      end
      else if (start_send)
      begin
        lstate <= L_SEND; // R10
        edge_en <= 1'b0;
      end
      else if (edge_flag && (lstate == L_WAIT || lstate == L_BEGIN)) // R3
      begin
        ts_last <= ts_now;
        if (lstate == L_WAIT)
        begin
          lstate <= L_BEGIN;
          ts_seg <= ts_now;
        end
        else if (since_last > GAP_TICKS) // R13
        begin
          if (seg_cnt + 2 > SEG_DEPTH)
          begin
            lstate <= L_DONE;
            status <= `IRWL_ST_FAIL_FULL;
            int_stat[`IRWL_INT_DONE] <= 1'b1;
          end
          else
          begin
            seg_mem[seg_cnt[AW-1:0]] <= ts_last - ts_seg; // R4
            seg_mem[seg_cnt[AW-1:0] + 1'b1] <= since_last;
            seg_cnt <= seg_cnt + 2'd2;
            ts_seg <= ts_now;
          end
        end
        else if (per_n < `IRWL_PERIOD_SAMPLES)
        begin
          per_sum <= per_sum + since_last; // R5
          per_n <= per_n + 1'b1;
          if (per_n == `IRWL_PERIOD_SAMPLES - 1)
            period <= per_total[TS_W-1+`IRWL_PERIOD_SHIFT:`IRWL_PERIOD_SHIFT];
        end
      end
      else if (done_evt)
      begin
        lstate <= L_DONE;
        edge_en <= 1'b0;
        int_stat[`IRWL_INT_DONE] <= 1'b1;
        if (lstate == L_WAIT)
          status <= `IRWL_ST_FAIL_TIMEOUT; // R6
        else if (seg_cnt + 1 > min_segs) // R7 R8
        begin
          status <= `IRWL_ST_SUCCESS;
          seg_mem[seg_cnt[AW-1:0]] <= ts_last - ts_seg;
          seg_cnt <= seg_cnt + 1'b1;
        end
        else
          status <= `IRWL_ST_FAIL_FEW;
      end
      else if (send_done)
      begin
        lstate <= L_DONE;
        int_stat[`IRWL_INT_SENT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Replay: carrier segments gate a one-third duty carrier.
  reg  [TS_W-1:0] car_cnt;
  reg  [TS_W-1:0] seg_left;
  reg  [AW:0]     tx_idx;
  reg  [7:0]      rep_left;
  reg             tx_run;
  wire            seg_end = tx_run && seg_left <= 1;
  wire            last_seg = tx_idx + 1 >= seg_cnt;

  always @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      car_cnt <= {TS_W{1'b0}};
      seg_left <= {TS_W{1'b0}};
      tx_idx <= {(AW+1){1'b0}};
      rep_left <= 8'h00;
      tx_run <= 1'b0;
      send_done <= 1'b0;
      O_IR_TRANSMIT_OUTPUT <= 1'b0;
      O_IR_DRIVER_CONTROL <= 1'b0;
      O_TRANSMIT_BUSY <= 1'b0;
      O_SUSPEND_BLOCK <= 1'b0;
      O_IRQ <= 1'b0;
    end
    else
    begin
      send_done <= 1'b0;
      O_IRQ <= |(int_stat & int_mask);
      car_cnt <= (car_cnt + 1'b1 >= period) ? {TS_W{1'b0}} : car_cnt + 1'b1;
      if (start_send)
      begin
        tx_run <= 1'b1;
        tx_idx <= {(AW+1){1'b0}};
        seg_left <= seg_mem[0];
        rep_left <= repeat_n;
        car_cnt <= {TS_W{1'b0}};
      end
      else if (seg_end)
      begin
        if (!last_seg)
        begin
          tx_idx <= tx_idx + 1'b1; // R9
          seg_left <= seg_mem[tx_idx[AW-1:0] + 1'b1];
        end
        else if (rep_left != 8'h00)
        begin
          rep_left <= rep_left - 1'b1; // R12
          tx_idx <= {(AW+1){1'b0}};
          seg_left <= seg_mem[0];
        end
        else
        begin
          tx_run <= 1'b0;
          send_done <= 1'b1;
        end
      end
      else if (tx_run)
        seg_left <= seg_left - 1'b1;
      O_TRANSMIT_BUSY <= tx_run || start_send; // R11
      O_SUSPEND_BLOCK <= tx_run || start_send; // R11
      O_IR_DRIVER_CONTROL <= tx_run && lstate == L_SEND; // R2
      O_IR_TRANSMIT_OUTPUT <= tx_run && !tx_idx[0] &&
                              (car_cnt * 3 < period); // R9
    end
  end
endmodule
`default_nettype wire

/* verif/irwl_monitor.sv */
`default_nettype none
module irwl_monitor (
  input wire logic        I_CLK,
  input wire logic        I_RST_N,
  input wire logic        O_IR_TRANSMIT_OUTPUT,
  input wire logic        O_IR_DRIVER_CONTROL,
  input wire logic        O_TRANSMIT_BUSY,
  input wire logic        O_SUSPEND_BLOCK,
  input wire logic        I_AWVALID,
  input wire logic        O_AWREADY,
  input wire logic        I_WVALID,
  input wire logic        O_WREADY,
  input wire logic        O_BVALID,
  input wire logic        I_BREADY,
  input wire logic [1:0]  O_BRESP,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic        O_RVALID,
  input wire logic        I_RREADY,
  input wire logic [31:0] O_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  logic [15:0] hi_run;
  // Length of the current high phase of the carrier output.
  always @(posedge I_CLK)
    if (!I_RST_N || !O_IR_TRANSMIT_OUTPUT)
      hi_run <= 16'h0;
    else
      hi_run <= hi_run + 16'h1;
  sequence s_wr_both;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence s_rd_take;
    I_ARVALID && O_ARREADY;
  endsequence
  chk_idle_pins_low: assert property (!O_TRANSMIT_BUSY &&
    !$past(O_TRANSMIT_BUSY) |-> !O_IR_TRANSMIT_OUTPUT && !O_IR_DRIVER_CONTROL)
    else $error("Transmit pins active outside replay.");
  chk_suspend_busy: assert property (O_SUSPEND_BLOCK == O_TRANSMIT_BUSY)
    else $error("Suspend block differs from busy.");
  chk_busy_drive: assert property (O_TRANSMIT_BUSY &&
    $past(O_TRANSMIT_BUSY) |-> O_IR_DRIVER_CONTROL)
    else $error("Driver control low during replay.");
  chk_tx_high_len: assert property (hi_run < 16'h08FC)
    else $error("Carrier high phase too long.");
  // The write is applied one edge after both halves are held.
  chk_wr_answer: assert property (s_wr_both |-> ##2 O_BVALID)
    else $error("Write response missing.");
  chk_rd_answer: assert property (s_rd_take |=> O_RVALID && !O_ARREADY)
    else $error("Read response missing.");
  chk_b_stands: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP))
    else $error("Write response dropped.");
  chk_r_stands: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA))
    else $error("Read response dropped.");
  chk_b_release: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("Write response held too long.");
endmodule
bind irwl_top irwl_monitor u_mon (.I_CLK, .I_RST_N, .O_IR_TRANSMIT_OUTPUT,
  .O_IR_DRIVER_CONTROL, .O_TRANSMIT_BUSY, .O_SUSPEND_BLOCK, .I_AWVALID,
  .O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID, .I_BREADY, .O_BRESP,
  .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY, .O_RDATA);
`default_nettype wire

/* verif/irwl_rx_model.sv */
`default_nettype none
module irwl_rx_model (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [3:0] i_bursts,
  output var  logic       o_rx_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulled up when idle; each burst is ten 40-tick carrier cycles.
  initial
  begin
    o_rx_n = 1'h1;
    forever
    begin
      @(posedge i_clk);
      if (i_go)
        repeat (i_bursts)
        begin
          repeat (10)
          begin
            o_rx_n <= 1'h0;
            repeat (13) @(posedge i_clk);
            o_rx_n <= 1'h1;
            repeat (27) @(posedge i_clk);
          end
          repeat (10400) @(posedge i_clk);
        end
    end
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
`include "irwl_consts.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, rx_n, go, awv, wv, bready, arv, rready;
  logic [3:0]  bursts;
  logic [31:0] awaddr, wdata, araddr, v;
  logic [1:0]  r;
  wire         tx, drv, busy, susp, irq, awr, wrdy, bv, arr, rv;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  integer      miscompares = 0;
  integer      check_count = 0;
  integer      hi, lo, k, nb;
  irwl_top #(.TIMEOUT_TICKS(2000), .END_TICKS(11000)) dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_IR_RECEIVE_INPUT_N(rx_n),
    .O_IR_TRANSMIT_OUTPUT(tx), .O_IR_DRIVER_CONTROL(drv),
    .O_TRANSMIT_BUSY(busy), .O_SUSPEND_BLOCK(susp), .O_IRQ(irq),
    .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wdata),
    .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(bresp),
    .O_BVALID(bv), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv),
    .I_RREADY(rready));
  irwl_rx_model rx (.i_clk(clk), .i_go(go), .i_bursts(bursts), .o_rx_n(rx_n));
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic give_verdict;
    $display("Counts: %0d checks, %0d mismatches", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    @(posedge clk);
    awaddr <= {26'h0, i, 2'h0};
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
    end
    while (!bv);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] i);
    @(posedge clk);
    araddr <= {26'h0, i, 2'h0};
    arv <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
    end
    while (!rv);
    v = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic rdchk(input logic [3:0] i, input logic [31:0] e);
    rd(i);
    chk(v, e);
  endtask
  // Starts a learn, lets the receiver send bursts and waits for a verdict.
  task automatic learn(input logic [3:0] b, input logic [31:0] e);
    integer n;
    n = 0;
    bursts <= b;
    wr(`IRWL_A_CTRL, 32'h1);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    do
    begin
      rd(`IRWL_A_STATUS);
      n++;
    end
    while (v === 32'h1 && n < 40000);
    chk(v, e);
  endtask
  initial
  begin
    rst_n = 1'h0;
    go = 1'h0;
    bursts = 4'h0;
    awv = 1'h0;
    wv = 1'h0;
    bready = 1'h0;
    arv = 1'h0;
    rready = 1'h0;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rdchk(`IRWL_A_MIN, 32'hF);
    rdchk(`IRWL_A_STATUS, 32'h1);
    rd(4'h9);
    chk({30'h0, r}, {30'h0, `IRWL_RESP_ERR});
    wr(4'h9, 32'h1);
    chk({30'h0, r}, {30'h0, `IRWL_RESP_ERR});
    wr(`IRWL_A_INT_MASK, 32'h0);
    learn(4'h0, `IRWL_ST_FAIL_TIMEOUT);
    chk({31'h0, irq}, 32'h0);
    wr(`IRWL_A_INT_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(`IRWL_A_INT_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    learn(4'h1, `IRWL_ST_FAIL_FEW);
    wr(`IRWL_A_CTRL, 32'h2);
    repeat (4) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    wr(`IRWL_A_MIN, 32'h2);
    learn(4'h2, `IRWL_ST_SUCCESS);
    rdchk(`IRWL_A_PERIOD, 32'h28);
    rdchk(`IRWL_A_COUNT, 32'h3);
    for (k = 0; k < 3; k++)
    begin
      wr(`IRWL_A_BUF, k);
      rdchk(`IRWL_A_BUF, (k == 1) ? 32'h28C8 : 32'h168);
    end
    wr(`IRWL_A_INT_STAT, 32'h3);
    wr(`IRWL_A_REPEAT, 32'h1);
    rdchk(`IRWL_A_REPEAT, 32'h1);
    wr(`IRWL_A_CTRL, 32'h2);
    nb = 0;
    while (tx !== 1'h1)
    begin
      @(posedge clk);
      nb++;
    end
    chk({30'h0, busy, susp}, 32'h3);
    chk({31'h0, drv}, 32'h1);
    hi = 0;
    lo = 0;
    while (tx === 1'h1)
    begin
      @(posedge clk);
      hi++;
    end
    while (tx !== 1'h1)
    begin
      @(posedge clk);
      lo++;
    end
    chk({31'h0, hi == 13 || hi == 14}, 32'h1);
    chk(hi + lo, 32'h28);
    while (busy !== 1'h0)
    begin
      @(posedge clk);
      nb++;
    end
    // Two whole frames of carrier, gap, carrier plus the busy register lag.
    chk(nb + hi + lo, 2 * (360 + 10440 + 360) + 1);
    rd(`IRWL_A_INT_STAT);
    chk({31'h0, v[`IRWL_INT_SENT]}, 32'h1);
    give_verdict;
  end
  initial
  begin
    repeat (80000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
endmodule
`default_nettype wire
